// File: common/lbcs_pkg.sv
// Constants shared by the local bus controller and its chip-select decoder
// Summary of operation
// - Drive 20-bit address, read/write strobes, status and data; capture read data.
// - Cycle lasts four clocks minimum, stretched while ready is withheld.
// - On hold request release the bus and raise acknowledge.
// - Drive data-enable and transceiver direction for external buffers.
// - In reset float address/data, upper address, byte-enable, direction; latch, ack low.
// - In reset drive lock and cycle status high first, then float.
// - In reset drive data-enable, read, write high one clock, then float.
// - Enable pull-ups on strap pins only while reset is asserted.
// - Decode straps: both selects low float, busy low-high enhanced, read low queue.
// - Queue mode puts queue state on latch and write pins.
// - Enhanced mode from busy strap; enhanced registers locked outside it.
// - Decoding identical for core and DMA cycles.
// - Upper select ends at top of memory; size fixed at the reset value, no write path.
// - Lower select starts at zero; only size programmable.
// - Four middle selects with programmable base and size.
// - Seven peripheral selects, 128-byte blocks from one base, memory or I/O.
// - Internal ready after zero to three programmed wait states per range.
// - External ready ignored, alone, or combined with wait states per range.
// - Output latched address bits one and two for the cycle.
// - All selects inactive high during reset, the middle selects one clock later through their unreset output register.
// - Upper select control loads the 1-Kbyte, three-wait, combined value on every clock while reset is asserted.
// - Other selects stay inactive until software writes their configuration.
// - Select low in a cycle whose address is inside its space, else high.
package lbcs_pkg;
	localparam logic [15:0] LBCS_UPPER_CTRL_RESET = 16'hFFFB;
	localparam int          LBCS_ADDR_W   = 20;
	localparam int          LBCS_MIN_T    = 4;
	localparam int          LBCS_PER_SIZE = 128;
	localparam int          LBCS_PER_NUM  = 7;
	localparam int          LBCS_MID_NUM  = 4;
	// Control word fields: size or base in [15:6], ready mode [2], waits [1:0]
	localparam int          LBCS_FLD_HI   = 15;
	localparam int          LBCS_FLD_LO   = 6;
	localparam int          LBCS_RDY_IGN  = 2;
	localparam int          LBCS_WAIT_HI  = 1;
	localparam int          LBCS_FLD_W    = 10;
	localparam int          LBCS_FLD_SH   = 10;
	localparam int          LBCS_PER_SH   = 7;
	localparam int          LBCS_RST_DRV  = 1;
	// Cycle status codes, active low on the pins
	localparam logic [2:0]  LBCS_ST_PASSIVE = 3'h7;
	localparam logic [2:0]  LBCS_ST_IO_RD   = 3'h1;
	localparam logic [2:0]  LBCS_ST_IO_WR   = 3'h2;
	localparam logic [2:0]  LBCS_ST_MEM_RD  = 3'h5;
	localparam logic [2:0]  LBCS_ST_MEM_WR  = 3'h6;
endpackage

// File: hw/lbcs_decode.sv
// Chip-select decoder with wait-state and ready selection
`timescale 1ns/1ns
`default_nettype none
module lbcs_decode (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	input  wire logic [19:0] i_addr,
	input  wire logic        i_mem,
	input  wire logic        i_valid,
	input  wire logic [15:0] i_upper_ctrl,
	input  wire logic [15:0] i_lower_ctrl,
	input  wire logic [15:0] i_mid_ctrl,
	input  wire logic [15:0] i_per_ctrl,
	input  wire logic [3:0]  i_cfg_valid,
	input  wire logic        i_per_is_mem,
	output logic             o_upper_n,
	output logic             o_lower_n,
	output logic [3:0]       o_mid_n,
	output logic [6:0]       o_per_n,
	output logic [1:0]       o_waits,
	output logic             o_ext_ignore,
	output logic             o_hit
);
	// ****************************************
	// Decode
	// ****************************************
	function automatic logic [19:0] lbcs_size(input logic [15:0] c);
		lbcs_size = {c[lbcs_pkg::LBCS_FLD_HI:lbcs_pkg::LBCS_FLD_LO],
			10'h000};
	endfunction

	logic        next_upper_n;
	logic        next_lower_n;
	logic [3:0]  next_mid_n;
	logic [6:0]  next_per_n;
	logic [1:0]  next_waits;
	logic        next_ign;
	logic        next_hit;
	logic [19:0] sz;
	logic [19:0] mbase;
	logic [19:0] pofs;
	logic [19:0] pbase;
	logic        pspace;

	always_comb begin
		next_upper_n = 1'b1;
		next_lower_n = 1'b1;
		next_mid_n   = 4'hF;
		next_per_n   = 7'h7F;
		next_waits   = 2'h0;
		next_ign     = 1'b1;
		next_hit     = 1'b0;
		pspace       = i_per_is_mem ? i_mem : ~i_mem;
		mbase        = {i_mid_ctrl[15:6], 10'h000};
		pbase        = {i_per_ctrl[15:6], 10'h000};
		pofs         = i_addr - pbase;
		sz           = '0;
		if (i_valid) begin
			sz = lbcs_size(~i_upper_ctrl) + 20'h00400;
			if (i_mem && i_addr >= 20'h00000 - sz) begin
				next_upper_n = 1'b0;
				next_hit     = 1'b1;
				next_waits   = i_upper_ctrl[1:0];
				next_ign     = i_upper_ctrl[2];
			end
			else if (i_cfg_valid[0] && i_mem &&
				i_addr < lbcs_size(i_lower_ctrl) + 20'h00400) begin
				next_lower_n = 1'b0;
				next_hit     = 1'b1;
				next_waits   = i_lower_ctrl[1:0];
				next_ign     = i_lower_ctrl[2];
			end
			else if (i_cfg_valid[1] && i_mem && i_addr >= mbase &&
				i_addr < mbase + {i_mid_ctrl[5:3], 17'h00000}) begin
				next_mid_n[2'(((i_addr - mbase) >> 15) & 20'h3)] = 1'b0;
				next_hit   = 1'b1;
				next_waits = i_mid_ctrl[1:0];
				next_ign   = i_mid_ctrl[2];
			end
			else if (i_cfg_valid[2] && pspace && i_addr >= pbase &&
				pofs < 20'(lbcs_pkg::LBCS_PER_NUM *
				lbcs_pkg::LBCS_PER_SIZE)) begin
				next_per_n[3'(pofs >> lbcs_pkg::LBCS_PER_SH)] = 1'b0;
				next_hit   = 1'b1;
				next_waits = i_per_ctrl[1:0];
				next_ign   = i_per_ctrl[2];
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_upper_n    <= 1'b1;
			o_lower_n    <= 1'b1;
			o_mid_n      <= 4'hF;
			o_per_n      <= 7'h7F;
			o_waits      <= 2'h0;
			o_ext_ignore <= 1'b1;
			o_hit        <= 1'b0;
		end else begin
			o_upper_n    <= next_upper_n;
			o_lower_n    <= next_lower_n;
			o_mid_n      <= next_mid_n;
			o_per_n      <= next_per_n;
			o_waits      <= next_waits;
			o_ext_ignore <= next_ign;
			o_hit        <= next_hit;
		end
	end

	a_sel_reset: assert property (@(posedge i_core_clk)
		i_rst |=> (o_upper_n && o_lower_n && &o_mid_n && &o_per_n))
		else $error("select active after reset");
	a_lower_cfg: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!i_cfg_valid[0] |=> o_lower_n)
		else $error("lower select without configuration");
endmodule
`default_nettype wire

// File: hw/lbcs_top.sv
// Local bus controller with strap sampling and chip-select unit
`timescale 1ns/1ns
`default_nettype none
module lbcs_top (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	// Core or DMA request
	input  wire logic        i_req,
	input  wire logic        i_req_write,
	input  wire logic        i_req_mem,
	input  wire logic [19:0] i_req_addr,
	input  wire logic [15:0] i_req_wdata,
	output logic             o_req_done,
	output logic [15:0]      o_req_rdata,
	// Chip-select configuration
	input  wire logic [15:0] i_lower_ctrl,
	input  wire logic [15:0] i_mid_ctrl,
	input  wire logic [15:0] i_per_ctrl,
	input  wire logic        i_per_is_mem,
	input  wire logic        i_lower_wr,
	input  wire logic        i_mid_wr,
	input  wire logic        i_per_wr,
	input  wire logic        i_enh_reg_access,
	output logic             o_enh_reg_grant,
	input  wire logic [1:0]  i_queue_state,
	// Bus pins
	input  wire logic [15:0] i_muxed_addr_data,
	output logic [15:0]      o_muxed_addr_data,
	output logic             o_muxed_addr_data_oe,
	output logic [3:0]       o_upper_address,
	output logic             o_upper_address_oe,
	output logic             o_byte_high_n,
	output logic             o_byte_high_oe,
	output logic             o_latch_or_queue_state0,
	output logic             o_read_n,
	output logic             o_read_oe,
	output logic             o_write_or_queue_state1,
	output logic             o_write_oe,
	output logic             o_data_enable_n,
	output logic             o_data_enable_oe,
	output logic             o_xcvr_direction,
	output logic             o_xcvr_direction_oe,
	output logic             o_cycle_status0_n,
	output logic             o_cycle_status1_n,
	output logic             o_cycle_status2_n,
	output logic             o_status_oe,
	output logic             o_lock_n,
	output logic             o_lock_oe,
	input  wire logic        i_sync_ready,
	input  wire logic        i_async_ready,
	input  wire logic        i_hold,
	output logic             o_hold_ack,
	// Strap pins
	input  wire logic        i_read_strap,
	input  wire logic        i_upper_select_pin,
	input  wire logic        i_lower_select_pin,
	input  wire logic        i_busy_strap,
	output logic             o_strap_pullup_en,
	output logic             o_all_pins_float_mode,
	output logic             o_enhanced_mode,
	output logic             o_queue_mode,
	// Selects
	output logic             o_upper_select_n,
	output logic             o_lower_select_n,
	output logic             o_middle_select0_n,
	output logic             o_middle_select1_n,
	output logic [1:0]       o_middle_select_hi_n,
	output logic [6:0]       o_per_select_n,
	output logic [1:0]       o_latched_a21
);
	// ****************************************
	// Synchronisers and straps
	// ****************************************
	logic [1:0] ardy_s;
	logic [1:0] hold_s;
	logic [1:0] busy_s;
	logic [2:0] strap_s0;
	logic [2:0] strap_s1;
	logic       busy_low_seen;
	logic       rst_d;
	logic       srdy_q;

	always_ff @(posedge i_core_clk) begin
		ardy_s   <= {ardy_s[0], i_async_ready};
		hold_s   <= {hold_s[0], i_hold};
		busy_s   <= {busy_s[0], i_busy_strap};
		strap_s0 <= {i_read_strap, i_upper_select_pin, i_lower_select_pin};
		strap_s1 <= strap_s0;
		srdy_q   <= i_sync_ready;
		rst_d    <= i_rst;
	end

	always_ff @(posedge i_core_clk) begin
		o_strap_pullup_en <= i_rst;
	end

	// strap decode
	// Straps caught on the cycle of reset release; busy must go low then high
	logic next_busy_low;
	always_comb begin
		next_busy_low = busy_low_seen;
		if (i_rst && !busy_s[1])
			next_busy_low = 1'b1;
	end
	always_ff @(posedge i_core_clk) begin
		if (i_rst && !rst_d) begin
			busy_low_seen <= 1'b0;
		end else begin
			busy_low_seen <= next_busy_low;
		end
		if (!i_rst && rst_d) begin
			o_all_pins_float_mode <= ~strap_s1[1] & ~strap_s1[0];
			o_queue_mode          <= ~strap_s1[2];
			o_enhanced_mode       <= busy_low_seen & busy_s[1];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst)
			o_enh_reg_grant <= 1'b0;
		else
			// Blocked on the release edge, while the captured mode still settles
			o_enh_reg_grant <= i_enh_reg_access & o_enhanced_mode & !rst_d;
	end

	logic [3:0] cfg_valid;
	logic [3:0] next_cfg_valid;
	logic [15:0] upper_select_ctrl;
	always_comb begin
		next_cfg_valid = cfg_valid | {1'b0, i_per_wr, i_mid_wr, i_lower_wr};
	end
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			cfg_valid         <= 4'h0;
			upper_select_ctrl <= lbcs_pkg::LBCS_UPPER_CTRL_RESET;
		end else begin
			cfg_valid <= next_cfg_valid;
		end
	end

	// ****************************************
	// Bus cycle machine
	// ****************************************
	typedef enum logic [2:0] {
		LBCS_RST1, LBCS_IDLE, LBCS_T1, LBCS_T2, LBCS_T3, LBCS_T4, LBCS_HOLD
	} lbcs_state_t;

	lbcs_state_t st;
	lbcs_state_t next_st;
	logic [19:0] addr;
	logic [19:0] next_addr;
	logic        wr;
	logic        next_wr;
	logic        mem;
	logic        next_mem;
	logic [15:0] wdata;
	logic [15:0] next_wdata;
	logic [1:0]  wcnt;
	logic [1:0]  next_wcnt;
	logic        dec_valid;
	logic        cs_hit;
	logic [1:0]  cs_waits;
	logic        cs_ign;
	logic [3:0]  mid_n;
	logic        rdy_ok;

	lbcs_decode u_dec (
		.i_core_clk   (i_core_clk),
		.i_rst        (i_rst),
		.i_addr       (addr),
		.i_mem        (mem),
		.i_valid      (dec_valid),
		.i_upper_ctrl (upper_select_ctrl),
		.i_lower_ctrl (i_lower_ctrl),
		.i_mid_ctrl   (i_mid_ctrl),
		.i_per_ctrl   (i_per_ctrl),
		.i_cfg_valid  (cfg_valid),
		.i_per_is_mem (i_per_is_mem),
		.o_upper_n    (o_upper_select_n),
		.o_lower_n    (o_lower_select_n),
		.o_mid_n      (mid_n),
		.o_per_n      (o_per_select_n),
		.o_waits      (cs_waits),
		.o_ext_ignore (cs_ign),
		.o_hit        (cs_hit)
	);

	always_ff @(posedge i_core_clk) begin
		o_middle_select0_n   <= mid_n[0];
		o_middle_select1_n   <= mid_n[1];
		o_middle_select_hi_n <= mid_n[3:2];
	end

	// ready selection
	// Unselected cycles rely on external ready; ignore bit ends on waits alone
	always_comb begin
		if (!cs_hit)
			rdy_ok = srdy_q | ardy_s[1];
		else if (cs_ign)
			rdy_ok = (wcnt == cs_waits);
		else
			rdy_ok = (wcnt == cs_waits) && (srdy_q | ardy_s[1]);
	end

	always_comb begin
		next_st    = st;
		next_addr  = addr;
		next_wr    = wr;
		next_mem   = mem;
		next_wdata = wdata;
		next_wcnt  = wcnt;
		case (st)
			LBCS_RST1: next_st = LBCS_IDLE;
			LBCS_IDLE: begin
				if (hold_s[1]) begin
					next_st = LBCS_HOLD;
				end else if (i_req) begin
					next_st    = LBCS_T1;
					next_addr  = i_req_addr;
					next_wr    = i_req_write;
					next_mem   = i_req_mem;
					next_wdata = i_req_wdata;
				end
			end
			LBCS_T1: next_st = LBCS_T2;
			LBCS_T2: begin
				next_st   = LBCS_T3;
				next_wcnt = 2'h0;
			end
			LBCS_T3: begin
				if (rdy_ok)
					next_st = LBCS_T4;
				else if (wcnt != 2'h3)
					next_wcnt = wcnt + 2'h1;
			end
			LBCS_T4: next_st = LBCS_IDLE;
			LBCS_HOLD: if (!hold_s[1]) next_st = LBCS_IDLE;
			default: next_st = LBCS_IDLE;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			st    <= LBCS_RST1;
			addr  <= 20'h00000;
			wr    <= 1'b0;
			mem   <= 1'b0;
			wdata <= 16'h0000;
			wcnt  <= 2'h0;
		end else begin
			st    <= next_st;
			addr  <= next_addr;
			wr    <= next_wr;
			mem   <= next_mem;
			wdata <= next_wdata;
			wcnt  <= next_wcnt;
		end
	end
	assign dec_valid = (st == LBCS_T1) || (st == LBCS_T2) ||
		(st == LBCS_T3);

	// ****************************************
	// Pin drive
	// ****************************************
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_muxed_addr_data_oe    <= 1'b0;
			o_muxed_addr_data       <= 16'h0000;
			o_upper_address_oe      <= 1'b0;
			o_upper_address         <= 4'h0;
			o_byte_high_oe          <= 1'b0;
			o_byte_high_n           <= 1'b1;
			o_xcvr_direction_oe     <= 1'b0;
			o_xcvr_direction        <= 1'b0;
			o_latch_or_queue_state0 <= 1'b0;
			o_hold_ack              <= 1'b0;
			o_lock_n                <= 1'b1;
			o_cycle_status0_n       <= 1'b1;
			o_cycle_status1_n       <= 1'b1;
			o_cycle_status2_n       <= 1'b1;
			o_status_oe             <= !rst_d;
			o_lock_oe               <= !rst_d;
			o_data_enable_n         <= 1'b1;
			o_read_n                <= 1'b1;
			o_write_or_queue_state1 <= 1'b1;
			o_data_enable_oe        <= !rst_d;
			o_read_oe               <= !rst_d;
			o_write_oe              <= !rst_d;
			o_req_done              <= 1'b0;
			o_req_rdata             <= 16'h0000;
			o_latched_a21           <= 2'h0;
		end else begin
			o_hold_ack <= (next_st == LBCS_HOLD);
			o_muxed_addr_data_oe <= (next_st == LBCS_T1) ||
				(next_wr && (next_st == LBCS_T2 || next_st == LBCS_T3));
			o_muxed_addr_data <= (next_st == LBCS_T1) ? next_addr[15:0]
				: next_wdata;
			o_upper_address_oe <= (next_st != LBCS_HOLD);
			o_upper_address    <= next_addr[19:16];
			o_byte_high_oe     <= (next_st != LBCS_HOLD);
			o_byte_high_n      <= 1'b0;
			o_status_oe        <= (next_st != LBCS_HOLD);
			o_lock_oe          <= (next_st != LBCS_HOLD);
			o_lock_n           <= 1'b1;
			{o_cycle_status2_n, o_cycle_status1_n, o_cycle_status0_n} <=
				(next_st == LBCS_T1) ? (next_mem ?
				(next_wr ? lbcs_pkg::LBCS_ST_MEM_WR
				: lbcs_pkg::LBCS_ST_MEM_RD)
				: (next_wr ? lbcs_pkg::LBCS_ST_IO_WR
				: lbcs_pkg::LBCS_ST_IO_RD))
				: lbcs_pkg::LBCS_ST_PASSIVE;
			o_read_oe  <= (next_st != LBCS_HOLD);
			o_write_oe <= (next_st != LBCS_HOLD);
			o_read_n   <= !(!next_wr && (next_st == LBCS_T2 ||
				next_st == LBCS_T3));
			// queue state replaces latch and write
			o_latch_or_queue_state0 <= o_queue_mode ? i_queue_state[0]
				: (next_st == LBCS_T1);
			o_write_or_queue_state1 <= o_queue_mode ? i_queue_state[1]
				: !(next_wr && (next_st == LBCS_T2 || next_st == LBCS_T3));
			o_data_enable_oe    <= (next_st != LBCS_HOLD);
			o_data_enable_n     <= !(next_st == LBCS_T2 ||
				next_st == LBCS_T3);
			o_xcvr_direction_oe <= (next_st != LBCS_HOLD);
			o_xcvr_direction    <= (next_st == LBCS_IDLE) ? 1'b1 : next_wr;
			if (next_st == LBCS_T1)
				o_latched_a21 <= next_addr[2:1];
			o_req_done <= (st == LBCS_T3) && rdy_ok;
			if (st == LBCS_T3 && rdy_ok && !wr)
				o_req_rdata <= i_muxed_addr_data;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	// four clocks minimum
	a_cycle_min: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(st == LBCS_IDLE && next_st == LBCS_T1) |=> !o_req_done [*3])
		else $error("bus cycle shorter than four clocks");
	a_hold_ack: assert property (@(posedge i_core_clk) disable iff (i_rst)
		o_hold_ack |-> !o_muxed_addr_data_oe && !o_status_oe)
		else $error("bus driven while acknowledged");
	a_rst_float: assert property (@(posedge i_core_clk)
		i_rst |=> !o_muxed_addr_data_oe && !o_xcvr_direction_oe &&
		!o_latch_or_queue_state0 && !o_hold_ack)
		else $error("bus not floated in reset");
	a_rst_strobe: assert property (@(posedge i_core_clk)
		(i_rst && rst_d) |=> !o_read_oe && !o_data_enable_oe)
		else $error("strobes driven beyond one clock");
	a_rst_status: assert property (@(posedge i_core_clk)
		(i_rst && !rst_d) |=> o_status_oe && o_cycle_status0_n && o_lock_n)
		else $error("status not driven high at reset");
	a_pullup: assert property (@(posedge i_core_clk)
		i_rst |=> o_strap_pullup_en)
		else $error("pull-ups off in reset");
	a_enh_lock: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!o_enhanced_mode |=> !o_enh_reg_grant)
		else $error("enhanced access outside enhanced mode");
	a_wait_cnt: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(st == LBCS_T3 && cs_hit && cs_ign && wcnt == cs_waits) |=>
		st == LBCS_T4)
		else $error("wait count not honoured");
	a_upper_rst: assert property (@(posedge i_core_clk)
		i_rst |=> upper_select_ctrl == lbcs_pkg::LBCS_UPPER_CTRL_RESET)
		else $error("upper select control reset value wrong");
	a_latch_a21: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(st == LBCS_T1) |-> o_latched_a21 == addr[2:1])
		else $error("latched address bits wrong");
	a_done_pulse: assert property (@(posedge i_core_clk) disable iff (i_rst)
		o_req_done |=> !o_req_done)
		else $error("done longer than one clock");

	c_io:    cover property (@(posedge i_core_clk) o_req_done && !mem);
	c_read:  cover property (@(posedge i_core_clk) o_req_done && !wr);
	c_write: cover property (@(posedge i_core_clk) o_req_done && wr);
	c_hold:  cover property (@(posedge i_core_clk) o_hold_ack);
	c_wait:  cover property (@(posedge i_core_clk) st == LBCS_T3 && wcnt == 2'h3);
endmodule
`default_nettype wire

// File: dv/lbcs_mem_model.sv
// Memory and peripheral model on the far side of the local bus
`timescale 1ns/1ns
`default_nettype none
module lbcs_mem_model (
	input  wire logic        i_core_clk,
	input  wire logic        i_slow,
	input  wire logic        i_latch,
	input  wire logic        i_read_n,
	input  wire logic        i_read_oe,
	input  wire logic        i_write_n,
	input  wire logic        i_write_oe,
	input  wire logic [3:0]  i_upper,
	input  wire logic [15:0] i_ad,
	output logic [15:0]      o_drive,
	output logic             o_drive_en,
	output logic             o_ready
);
	logic [15:0] mem [16];
	logic [19:0] addr;
	int          strobe_cnt = 0;
	always_ff @(posedge i_core_clk) begin
		if (i_latch)
			addr <= {i_upper, i_ad};
		if (i_write_oe && !i_write_n)
			mem[addr[4:1]] <= i_ad;
		strobe_cnt <= (!i_read_n || !i_write_n) ? strobe_cnt + 1 : 0;
	end
	// slow mode withholds ready for three strobe clocks
	assign o_ready    = !i_slow || strobe_cnt >= 3;
	// drive read data only while strobe is active
	assign o_drive_en = i_read_oe && !i_read_n;
	assign o_drive    = mem[addr[4:1]];
endmodule
`default_nettype wire

// File: dv/tb_local_bus_chip_select.sv
// Self-checking bench for the local bus controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_local_bus_chip_select;
	logic clk = 0, rst = 0, req = 0, req_w = 0, done, lwr = 0, slow = 0;
	logic [19:0] addr = 0;
	logic [15:0] wdata = 0, rdata, lctrl = 0, ad_o, pm_d, fp = 16'h5A5A;
	logic [15:0] bus, seed = 16'h0063;
	logic ad_oe, latch, rd_n, rd_oe, wr_n, wr_oe, hold = 0, hack, pull, pm_en;
	logic rs = 1, us = 1, ls = 1, bs = 1, flt, enh, qm, usel, lsel, rdy;
	logic enh_acc = 0, grant, ua_oe, mem_sp = 1;
	logic [1:0] qs = 0, la;
	logic [2:0] cst;
	logic [3:0] ua;
	logic [16:0] q [$];
	int err_count = 0, n_compared = 0, n_fast, n;
	always #5 clk = ~clk;
	always @(posedge clk) fp <= ~fp;
	assign bus = pm_en ? pm_d : (ad_oe ? ad_o : fp);
	lbcs_top lbcs_top_inst (.i_core_clk(clk), .i_rst(rst), .i_req(req),
		.i_req_write(req_w), .i_req_mem(mem_sp), .i_req_addr(addr),
		.i_req_wdata(wdata), .o_req_done(done), .o_req_rdata(rdata),
		.i_lower_ctrl(lctrl), .i_mid_ctrl(16'h0000), .i_per_ctrl(16'h0000),
		.i_per_is_mem(1'b0), .i_lower_wr(lwr), .i_mid_wr(1'b0),
		.i_per_wr(1'b0), .i_enh_reg_access(enh_acc),
		.o_enh_reg_grant(grant), .i_queue_state(qs),
		.i_muxed_addr_data(bus), .o_muxed_addr_data(ad_o),
		.o_muxed_addr_data_oe(ad_oe), .o_upper_address(ua),
		.o_upper_address_oe(ua_oe), .o_byte_high_n(), .o_byte_high_oe(),
		.o_latch_or_queue_state0(latch), .o_read_n(rd_n), .o_read_oe(rd_oe),
		.o_write_or_queue_state1(wr_n), .o_write_oe(wr_oe),
		.o_data_enable_n(), .o_data_enable_oe(), .o_xcvr_direction(),
		.o_xcvr_direction_oe(), .o_cycle_status0_n(cst[0]),
		.o_cycle_status1_n(cst[1]), .o_cycle_status2_n(cst[2]),
		.o_status_oe(), .o_lock_n(), .o_lock_oe(),
		.i_sync_ready(rdy), .i_async_ready(rdy), .i_hold(hold),
		.o_hold_ack(hack), .i_read_strap(rs), .i_upper_select_pin(us),
		.i_lower_select_pin(ls), .i_busy_strap(bs), .o_strap_pullup_en(pull),
		.o_all_pins_float_mode(flt), .o_enhanced_mode(enh),
		.o_queue_mode(qm), .o_upper_select_n(usel), .o_lower_select_n(lsel),
		.o_middle_select0_n(), .o_middle_select1_n(),
		.o_middle_select_hi_n(), .o_per_select_n(), .o_latched_a21(la));
	lbcs_mem_model lbcs_mem_model_inst (.i_core_clk(clk), .i_slow(slow),
		.i_latch(latch), .i_read_n(rd_n), .i_read_oe(rd_oe), .i_write_n(wr_n),
		.i_write_oe(wr_oe), .i_upper(ua), .i_ad(bus), .o_drive(pm_d),
		.o_drive_en(pm_en), .o_ready(rdy));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic summarize();
		$display("compared %0d errors %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Reset with the given strap levels; busy starts at the given level, raised high during reset
	task automatic do_reset(input logic r, u, l, b);
		int rd_hi;
		rd_hi = 0;
		@(negedge clk);
		{rst, rs, us, ls, bs} = {1'b1, r, u, l, b};
		for (int i = 0; i < 5; i++) begin
			@(negedge clk);
			rd_hi += (rd_oe === 1'b1);
			`CHK("usel", 1'b1, usel)
			// Busy rises early enough to cross the strap synchroniser
			if (i == 2)
				bs = 1;
		end
		`CHK("rd_oe_cycles", 1, rd_hi)
		`CHK("bus_oe", 2'b00, {ad_oe, ua_oe})
		`CHK("ack_ale", 2'b00, {hack, latch})
		`CHK("pullup", 1'b1, pull)
		rst = 0;
		repeat (2) @(negedge clk);
		{rs, us, ls} = 3'b111;
		@(negedge clk);
		`CHK("pullup_off", 1'b0, pull)
	endtask
	// One bus cycle; n returns clocks from request to done
	task automatic bus_op(input logic w, input logic [19:0] a,
		input logic [15:0] d, input logic [1:0] exp_sel);
		logic [1:0] seen;
		logic [2:0] exp_st;
		seen = 2'b00;
		n = 0;
		exp_st = w ? lbcs_pkg::LBCS_ST_MEM_WR : lbcs_pkg::LBCS_ST_MEM_RD;
		if (!mem_sp)
			exp_st = w ? lbcs_pkg::LBCS_ST_IO_WR : lbcs_pkg::LBCS_ST_IO_RD;
		@(negedge clk);
		{req, req_w, addr, wdata} = {1'b1, w, a, d};
		q.push_back({!w, d});
		do begin
			@(negedge clk);
			n++;
			seen |= {!usel, !lsel};
			if (n == 1)
				`CHK("status", exp_st, cst)
			if (n > 100) begin
				err_count++;
				summarize();
			end
		end while (done !== 1'b1);
		req = 0;
		`CHK("selects", exp_sel, seen)
		`CHK("a21", a[2:1], la)
	endtask
	always @(posedge clk) begin
		if (done === 1'b1 && q.size() > 0) begin
			if (q[0][16])
				`CHK("rdata", q[0][15:0], rdata)
			void'(q.pop_front());
		end
	end
	initial begin
		// ****************************************
		// Strap decoding
		// ****************************************
		do_reset(1'b0, 1'b1, 1'b1, 1'b0);
		qs = 2'b01;
		enh_acc = 1;
		repeat (3) @(negedge clk);
		`CHK("modes_q_e", 3'b011, {flt, enh, qm})
		`CHK("grant_enh", 1'b1, grant)
		`CHK("queue_pin", qs[0], latch)
		do_reset(1'b1, 1'b0, 1'b0, 1'b1);
		`CHK("modes_float", 3'b100, {flt, enh, qm})
		do_reset(1'b1, 1'b1, 1'b1, 1'b1);
		repeat (2) @(negedge clk);
		`CHK("modes_none", 3'b000, {flt, enh, qm})
		`CHK("grant_off", 1'b0, grant)
		enh_acc = 0;
		// ****************************************
		// Upper select with random data
		// ****************************************
		repeat (4) begin
			seed = lfsr(seed);
			bus_op(1'b1, 20'hFFFF0 + {seed[3:1], 1'b0}, seed, 2'b10);
			bus_op(1'b0, 20'hFFFF0 + {seed[3:1], 1'b0}, seed, 2'b10);
			// A lower count means the three reset waits were skipped
			`CHK("upper_waits", lbcs_pkg::LBCS_MIN_T + 3, n)
		end
		// I/O cycles never raise a memory select
		mem_sp = 0;
		bus_op(1'b1, 20'hFFFFE, seed, 2'b00);
		mem_sp = 1;
		// ****************************************
		// Lower select before and after configuration
		// ****************************************
		bus_op(1'b1, 20'h00010, 16'hC3A5, 2'b00);
		n_fast = n;
		slow = 1;
		bus_op(1'b0, 20'h00010, 16'hC3A5, 2'b00);
		`CHK("stretch", 1'b1, n > n_fast && n_fast >= 4)
		@(negedge clk);
		lctrl = 16'h0004;
		lwr = 1;
		@(negedge clk);
		lwr = 0;
		bus_op(1'b0, 20'h00010, 16'hC3A5, 2'b01);
		// Ready ignored, so the slow partner must not stretch it
		`CHK("ignore_rdy", lbcs_pkg::LBCS_MIN_T, n)
		slow = 0;
		// ****************************************
		// Hold handshake
		// ****************************************
		hold = 1;
		n = 0;
		while (hack !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		`CHK("hold_ack", 1'b1, hack)
		`CHK("hold_float", 2'b00, {ad_oe, ua_oe})
		hold = 0;
		repeat (6) @(negedge clk);
		`CHK("ack_drop", 1'b0, hack)
		summarize();
	end
endmodule
`default_nettype wire
